/* logic/rebv_ctrl.sv */
// Purpose: reset entry, reset pin drive and boot vector choice
// Assumes: request inputs synchronous to clock_i, held for a cycle or more
// Notes:   ram contents are never touched; no reset path goes to memory
//
// Summary of operation
// - while any reset is active the core fetch enable stays low.
// - module registers take defaults on reset, por-only bits only on por.
// - port pins are forced to a known state throughout reset.
// - interrupt and timer enables are cleared on reset entry.
// - reset never writes ram; the ram preserve output stays high.
// - port latches go to all ones and pins to open-drain on reset.
// - weak pull-ups are on during reset and remain on afterwards.
// - the reset pin is driven low for por and supply resets until exit.
// - on exit the program counter loads the start vector and the internal clock is chosen.
// - the watchdog is running on exit with no software action.
// - nine request sources feed the controller.
// - the flash byte below the lock byte is the boot signature, a5 valid.
// - any other signature value means no bootloader.
// - with a bootloader the first fetch after any reset is its vector.
// - without a bootloader execution starts at address 0000.
`timescale 1ns/10ps
module rebv_ctrl
    import rebv_pkg::*;
#(
    parameter int         PORT_W   = 8,
    parameter logic [15:0] BOOT_VEC = BOOT_VEC_DEF
) (
    // clock and master reset
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    // reset requests, one bit per source
    input  wire logic [SRC_COUNT-1:0] reset_req_i,
    // flash signature byte
    input  wire logic [7:0]        boot_sig_i,
    // core control
    output logic                   fetch_en_o,
    output logic [15:0]            start_pc_o,
    output logic                   pc_load_o,
    output logic                   module_rst_o,
    output logic                   por_rst_o,
    output logic                   ram_keep_o,
    // system
    output logic [1:0]             clk_sel_o,
    output logic                   wdog_en_o,
    output logic                   irq_en_o,
    output logic                   timer_en_o,
    // port pins
    output logic [PORT_W-1:0]      port_latch_o,
    output logic                   port_open_drain_o,
    output logic                   port_pullup_o,
    // reset pin drive
    output logic                   reset_pin_n_o,
    output logic                   reset_pin_oe_o,
    // last reset cause
    output logic [SRC_COUNT-1:0]   reset_cause_o
);
    ////////////////////////////////////////////////////////////////////
    logic        any_req;
    logic        hold;
    logic        pin_pull;
    logic        next_pin_pull;
    rebv_state_t state;
    rebv_state_t next_state;
    logic [SRC_COUNT-1:0] cause;
    logic [SRC_COUNT-1:0] next_cause;
    logic        fetch;
    logic        next_fetch;
    logic [15:0] pc;
    logic [15:0] next_pc;
    logic        pc_load;
    logic        next_pc_load;

    // rst_i acts as an extra power-on request
    assign any_req = rst_i | (|reset_req_i);

    rebv_sync #(
        .STAGES (SYNC_STAGES)
    ) u_sync (
        .clock_i (clock_i),
        .req_i   (any_req),
        .hold_o  (hold)
    );

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state   = state;
        next_fetch   = 1'b0;
        next_pc      = pc;
        next_pc_load = 1'b0;
        next_cause   = cause;
        if (any_req) begin
            next_cause = cause | reset_req_i;
            if (state == RB_RUN) begin
                next_cause = reset_req_i;
            end
        end
        if (rst_i) begin
            next_cause = SRC_RST[SRC_COUNT-1:0];
            next_cause[SRC_POR] = 1'b1;
        end
        unique case (state)
            RB_HOLD: begin
                next_pc = RESET_VECTOR;
                if (!any_req) begin
                    next_state = RB_SYNC;
                end
            end
            RB_SYNC: begin
                if (any_req) begin
                    next_state = RB_HOLD;
                end else if (!hold) begin
                    next_state = RB_DEC;
                end
            end
            RB_DEC: begin
                if (any_req) begin
                    next_state = RB_HOLD;
                end else begin
                    // vector decided once per exit, whatever the cause
                    if (rebv_boot_present(boot_sig_i)) begin
                        next_pc = BOOT_VEC;
                    end else begin
                        next_pc = RESET_VECTOR;
                    end
                    next_pc_load = 1'b1;
                    next_fetch   = 1'b1;
                    next_state   = RB_RUN;
                end
            end
            RB_RUN: begin
                next_fetch = 1'b1;
                if (any_req) begin
                    next_state = RB_HOLD;
                    next_fetch = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state   <= RB_HOLD;
            fetch   <= 1'b0;
            pc      <= RESET_VECTOR;
            pc_load <= 1'b0;
        end else begin
            state   <= next_state;
            fetch   <= next_fetch;
            pc      <= next_pc;
            pc_load <= next_pc_load;
        end
        cause <= next_cause;
    end

    ////////////////////////////////////////////////////////////////////
    // pin pull held from request until the exit decision
    always_comb begin
        next_pin_pull = pin_pull;
        if (rst_i | reset_req_i[SRC_POR] | reset_req_i[SRC_SUPPLY]) begin
            next_pin_pull = 1'b1;
        end else if (state == RB_DEC && !any_req) begin
            // a fresh request at the decision point keeps the pin low
            next_pin_pull = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        pin_pull <= next_pin_pull;
    end

    ////////////////////////////////////////////////////////////////////
    // core control comes straight from the state flops
    assign fetch_en_o = fetch;
    assign start_pc_o = pc;
    assign pc_load_o  = pc_load;

    ////////////////////////////////////////////////////////////////////
    logic              next_in_reset;
    logic              next_por;
    logic [1:0]        next_clk_sel;
    logic              next_wdog_en;
    logic              next_irq_en;
    logic              next_timer_en;
    logic [PORT_W-1:0] next_port_latch;
    logic              next_open_drain;

    // outside reset these hold; software owns them through other logic
    always_comb begin
        next_in_reset   = any_req | (next_state != RB_RUN);
        next_por        = rst_i | reset_req_i[SRC_POR];
        next_clk_sel    = clk_sel_o;
        next_wdog_en    = wdog_en_o;
        next_irq_en     = irq_en_o;
        next_timer_en   = timer_en_o;
        next_port_latch = port_latch_o;
        next_open_drain = port_open_drain_o;
        if (next_in_reset) begin
            next_clk_sel    = CLK_SEL_INT;
            next_wdog_en    = 1'b1;
            next_irq_en     = 1'b0;
            next_timer_en   = 1'b0;
            next_port_latch = {PORT_W{1'b1}};
            next_open_drain = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        module_rst_o      <= next_in_reset;
        por_rst_o         <= next_por;
        ram_keep_o        <= 1'b1;
        clk_sel_o         <= next_clk_sel;
        wdog_en_o         <= next_wdog_en;
        irq_en_o          <= next_irq_en;
        timer_en_o        <= next_timer_en;
        port_latch_o      <= next_port_latch;
        port_open_drain_o <= next_open_drain;
        port_pullup_o     <= 1'b1;
        reset_pin_n_o     <= ~next_pin_pull;
        reset_pin_oe_o    <= next_pin_pull;
        reset_cause_o     <= next_cause;
    end
endmodule : rebv_ctrl

/* logic/rebv_pkg.sv */
// Purpose: constants for the reset entry and boot vector controller
// Assumes: one system clock, synchronous active-high reset
// Notes:   nine reset sources, one bit each in the request vector
package rebv_pkg;
    localparam int          SRC_COUNT     = 9;
    localparam int          SRC_POR       = 0;
    localparam int          SRC_PIN       = 1;
    localparam int          SRC_CMP       = 2;
    localparam int          SRC_SW        = 3;
    localparam int          SRC_SUPPLY    = 4;
    localparam int          SRC_WDOG      = 5;
    localparam int          SRC_MCLK      = 6;
    localparam int          SRC_FLASH     = 7;
    localparam int          SRC_USB       = 8;
    localparam logic [7:0]  BOOT_SIG_CODE = 8'ha5;
    localparam logic [15:0] RESET_VECTOR  = 16'h0000;
    localparam logic [15:0] BOOT_VEC_DEF  = 16'h9a00;
    localparam int          SYNC_STAGES   = 2;
    localparam logic [1:0]  CLK_SEL_INT   = 2'h0;
    localparam logic [7:0]  PORT_LATCH_RST = 8'hff;
    localparam logic [9:0]  SRC_RST       = 10'h000;

    typedef enum logic [3:0] {
        RB_HOLD  = 4'h1,
        RB_SYNC  = 4'h2,
        RB_DEC   = 4'h4,
        RB_RUN   = 4'h8
    } rebv_state_t;

    // true when the flash signature marks an installed bootloader
    function automatic logic rebv_boot_present(input logic [7:0] sig);
        return sig == BOOT_SIG_CODE;
    endfunction : rebv_boot_present
endpackage : rebv_pkg

/* logic/rebv_sync.sv */
// Purpose: release synchroniser for the combined internal reset
// Assumes: request held until its source drops
// Notes:   assertion is immediate, release takes STAGES clocks
`timescale 1ns/10ps
module rebv_sync
    import rebv_pkg::*;
#(
    parameter int STAGES = SYNC_STAGES
) (
    // clock
    input  wire logic clock_i,
    // combined request
    input  wire logic req_i,
    // stretched reset
    output logic      hold_o
);
    logic [STAGES-1:0] chain;
    logic [STAGES-1:0] next_chain;

    always_comb begin
        if (req_i) begin
            next_chain = '1;
        end else begin
            next_chain = {chain[STAGES-2:0], 1'b0};
        end
    end

    always_ff @(posedge clock_i) begin
        chain <= next_chain;
    end

    assign hold_o = req_i | chain[STAGES-1];
endmodule : rebv_sync

/* tb/rebv_ctrl_assertions.sv */
// Purpose: port checks for reset entry, exit and vector choice
// Assumes: no new request until exit has completed
// Notes:   exit bounded at ten cycles after requests drop
`timescale 1ns/10ps
module rebv_ctrl_chk
    import rebv_pkg::*;
#(
    parameter int          PORT_W   = 8,
    parameter logic [15:0] BOOT_VEC = BOOT_VEC_DEF
) (
    input wire logic                 clock_i,
    input wire logic                 rst_i,
    input wire logic [SRC_COUNT-1:0] reset_req_i,
    input wire logic [7:0]           boot_sig_i,
    input wire logic                 fetch_en_o,
    input wire logic [15:0]          start_pc_o,
    input wire logic                 pc_load_o,
    input wire logic                 module_rst_o,
    input wire logic                 por_rst_o,
    input wire logic                 ram_keep_o,
    input wire logic [1:0]           clk_sel_o,
    input wire logic                 wdog_en_o,
    input wire logic                 irq_en_o,
    input wire logic                 timer_en_o,
    input wire logic [PORT_W-1:0]    port_latch_o,
    input wire logic                 port_open_drain_o,
    input wire logic                 port_pullup_o,
    input wire logic                 reset_pin_n_o,
    input wire logic                 reset_pin_oe_o,
    input wire logic [SRC_COUNT-1:0] reset_cause_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    AST_HALT: assert property (
        |reset_req_i |=> !fetch_en_o && module_rst_o)
        else $error("fetch not halted by request");
    AST_PORT: assert property (
        |reset_req_i |=> port_latch_o == '1 && port_open_drain_o)
        else $error("port state wrong in reset");
    AST_OFF: assert property (
        |reset_req_i |=> !irq_en_o && !timer_en_o)
        else $error("irq or timer left on");
    AST_KEEP: assert property (
        ram_keep_o && port_pullup_o)
        else $error("ram keep or pullup low");
    AST_PIN: assert property (
        reset_req_i[SRC_POR] || reset_req_i[SRC_SUPPLY]
        |=> reset_pin_oe_o && !reset_pin_n_o)
        else $error("reset pin not driven low");
    AST_PORB: assert property (
        reset_req_i[SRC_POR] |=> por_rst_o && module_rst_o)
        else $error("por reset not flagged");
    AST_EXIT: assert property (
        $rose(fetch_en_o) |-> pc_load_o && wdog_en_o
        && clk_sel_o == CLK_SEL_INT && !reset_pin_oe_o)
        else $error("exit state wrong");
    AST_VEC: assert property (
        $rose(fetch_en_o) |-> start_pc_o == ((boot_sig_i == BOOT_SIG_CODE)
        ? BOOT_VEC : RESET_VECTOR))
        else $error("start vector wrong");
    AST_SYNC: assert property (
        $fell(|reset_req_i) |-> !fetch_en_o [*2] ##[1:8] fetch_en_o)
        else $error("release not synchronised");
    AST_CAUSE: assert property (
        |reset_req_i |=> (reset_cause_o & $past(reset_req_i))
        == $past(reset_req_i))
        else $error("reset cause lost");
endmodule : rebv_ctrl_chk
bind rebv_ctrl rebv_ctrl_chk #(.PORT_W(PORT_W), .BOOT_VEC(BOOT_VEC)) chk (.*);

/* tb/rebv_src_model.sv */
// Purpose: reset sources and board reset wire
// Assumes: bench sets req between clock edges
// Notes:   wire has a pull-up, so released pin reads high
`timescale 1ns/10ps
module rebv_src_model
    import rebv_pkg::*;
(
    input  wire logic                 reset_pin_n_o,
    input  wire logic                 reset_pin_oe_o,
    output logic [SRC_COUNT-1:0]      reset_req_i,
    output logic                      pin_lvl
);
    logic [SRC_COUNT-1:0] req = '0;
    assign reset_req_i = req;
    assign pin_lvl = reset_pin_oe_o ? reset_pin_n_o : 1'b1;
endmodule : rebv_src_model

/* tb/tb.sv */
// Purpose: random and corner reset sequences
// Assumes: 10 MHz clock, inputs moved 10 ns after edges
// Notes:   boot vector set off default to catch a fixed constant
`timescale 1ns/10ps
module tb;
    import rebv_pkg::*;
    localparam logic [15:0] TB_VEC = 16'h4c00;
    logic clock_i, rst_i, pin_lvl, fetch_en_o, pc_load_o, module_rst_o;
    logic por_rst_o, ram_keep_o, wdog_en_o, irq_en_o, timer_en_o;
    logic port_open_drain_o, port_pullup_o, reset_pin_n_o, reset_pin_oe_o;
    logic [SRC_COUNT-1:0] reset_req_i, reset_cause_o;
    logic [15:0] start_pc_o;
    logic [7:0] boot_sig_i, port_latch_o;
    logic [1:0] clk_sel_o;
    int n_errors, comparisons, k;
    rebv_src_model src (.*);
    rebv_ctrl #(.BOOT_VEC(TB_VEC)) uut (.*);
    initial begin
        clock_i = 0;
        forever #50 clock_i = ~clock_i;
    end
    function automatic logic [15:0] exp_pc(input logic [7:0] s);
        return (s == 8'ha5) ? TB_VEC : RESET_VECTOR;
    endfunction : exp_pc
    task automatic chk(input string nm, input logic [15:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic give_verdict;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    task automatic run(input logic [SRC_COUNT-1:0] m, input int n,
                       input logic [7:0] s);
        int i;
        boot_sig_i = s;
        src.req = m;
        @(posedge clock_i);
        #10;
        chk("fetch", 16'h0, 16'(fetch_en_o));
        chk("mrst", 16'h1, 16'(module_rst_o));
        chk("por", 16'(m[SRC_POR]), 16'(por_rst_o));
        chk("latch", 16'hff, 16'(port_latch_o));
        chk("od", 16'h1, 16'(port_open_drain_o));
        chk("irq", 16'h0, 16'({irq_en_o, timer_en_o}));
        chk("pin", 16'(!(m[SRC_POR] | m[SRC_SUPPLY])), 16'(pin_lvl));
        repeat (n) @(posedge clock_i);
        #10;
        src.req = '0;
        for (i = 0; i < 20 && fetch_en_o !== 1'b1; i++) begin
            @(posedge clock_i);
            #10;
        end
        chk("go", 16'h1, 16'(fetch_en_o));
        chk("mrst_x", 16'h0, 16'(module_rst_o));
        chk("pc", exp_pc(s), start_pc_o);
        chk("load", 16'h1, 16'(pc_load_o));
        chk("clk", 16'(CLK_SEL_INT), 16'(clk_sel_o));
        chk("wdog", 16'h1, 16'(wdog_en_o));
        chk("keep", 16'h3, 16'({ram_keep_o, port_pullup_o}));
        chk("rel", 16'h1, 16'(pin_lvl));
        chk("cause", 16'(m), 16'(reset_cause_o));
        $display("test mask %h sig %h done", m, s);
        repeat (10) @(posedge clock_i);
        #10;
    endtask : run
    initial begin
        #(100 * 5000);
        n_errors++;
        give_verdict();
    end
    initial begin
        rst_i = 1'b1;
        boot_sig_i = 8'ha5;
        void'($urandom(32'hd813c046));
        repeat (6) @(posedge clock_i);
        #10;
        rst_i = 1'b0;
        repeat (10) @(posedge clock_i);
        #10;
        chk("por_pc", TB_VEC, start_pc_o);
        for (k = 0; k < SRC_COUNT; k++) begin
            run(9'h1 << k, 1 + k % 3, k[0] ? 8'ha5 : 8'ha4);
        end
        for (k = 0; k < 12; k++) begin
            run(9'($urandom_range(511, 1)), $urandom_range(4, 1),
                (k % 3 == 0) ? 8'ha5 : 8'($urandom));
        end
        // master reset in mid-run acts as a power-on request
        boot_sig_i = 8'h5a;
        rst_i = 1'b1;
        repeat (2) @(posedge clock_i);
        #10;
        chk("rst_por", 16'h1, 16'(por_rst_o));
        chk("rst_fetch", 16'h0, 16'(fetch_en_o));
        chk("rst_pin", 16'h0, 16'(pin_lvl));
        chk("rst_cause", 16'h1, 16'(reset_cause_o));
        rst_i = 1'b0;
        repeat (6) @(posedge clock_i);
        #10;
        chk("rst_go", 16'h1, 16'(fetch_en_o));
        chk("rst_pc", RESET_VECTOR, start_pc_o);
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule : tb
